// >>> design/aci_exec.sv
/*
 * Command executor for accumulator transfers, error-flag clearing and interrupt control.
 * Assumes frames arrive as nine bytes on a byte strobe, and AXI4-Lite for the registers.
 */
// Local design decisions: the address map and the AXI4-Lite register port.
module aci_exec
	import aci_pkg::*;
#(
	parameter int NIRQ = 16,
	parameter int IW = 4
) (
	// Clock and reset
	input wire logic CLK_SYS,
	input wire logic RESETN,
	input wire logic CE,
	// Command bytes
	input wire logic BYTE_VALID,
	input wire logic [7:0] BYTE_DATA,
	// Reply
	output logic REPLY_VALID,
	output logic [7:0] REPLY_STATUS,
	output logic [7:0] REPLY_INSTR,
	// Parameter write-out
	output logic AXIS_WR,
	output logic [7:0] AXIS_INDEX,
	output logic [7:0] AXIS_MOTOR,
	output logic GLOBAL_WR,
	output logic [7:0] GLOBAL_INDEX,
	output logic [7:0] GLOBAL_BANK,
	output logic USERVAR_WR,
	output logic [31:0] PARAM_DATA,
	// Error events, interrupt sources and program counter
	input wire logic [ERR_COUNT-1:0] ERR_SET,
	input wire logic [NIRQ-1:0] IRQ_REQ,
	output logic [31:0] PC_OUT,
	// AXI4-Lite and interrupt output
	input wire logic [7:0] AWADDR,
	input wire logic AWVALID,
	output logic AWREADY,
	input wire logic [31:0] WDATA,
	input wire logic [3:0] WSTRB,
	input wire logic WVALID,
	output logic WREADY,
	output logic [1:0] BRESP,
	output logic BVALID,
	input wire logic BREADY,
	input wire logic [7:0] ARADDR,
	input wire logic ARVALID,
	output logic ARREADY,
	output logic [31:0] RDATA,
	output logic [1:0] RRESP,
	output logic RVALID,
	input wire logic RREADY,
	output logic IRQ
);
	// ----------------------------------------------------------------
	// Frame assembly
	// ----------------------------------------------------------------
	logic [7:0] frame_reg [9];
	logic [3:0] cnt_reg;
	logic [7:0] sum_reg;
	logic run_reg;
	wire frame_end = BYTE_VALID && cnt_reg == 4'd8;
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			cnt_reg <= 4'd0;
			sum_reg <= 8'h00;
			run_reg <= 1'b0;
		end else if (CE) begin
			run_reg <= frame_end && BYTE_DATA == sum_reg;
			if (BYTE_VALID) begin
				cnt_reg <= frame_end ? 4'd0 : cnt_reg + 4'd1;
				sum_reg <= frame_end ? 8'h00 : sum_reg + BYTE_DATA;
			end
		end
	end
	always_ff @(posedge CLK_SYS) begin
		if (CE && BYTE_VALID) begin
			frame_reg[cnt_reg] <= BYTE_DATA;
		end
	end
	logic bad_sum_reg;
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			bad_sum_reg <= 1'b0;
		end else if (CE) begin
			bad_sum_reg <= frame_end && BYTE_DATA != sum_reg;
		end
	end

	wire [7:0] op = frame_reg[1];
	wire [7:0] typ = frame_reg[2];
	wire [7:0] bank = frame_reg[3];
	wire [31:0] value = {frame_reg[4], frame_reg[5], frame_reg[6], frame_reg[7]};
	wire type_global = typ == TYPE_GLOBAL;
	wire type_irq_ok = typ < 8'(NIRQ);
	wire bank_ok = bank == BANK_ZERO || bank == BANK_USER || bank == BANK_THREE;

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	wire do_axis = run_reg && op == OP_ACCU_AXIS;
	wire do_glob = run_reg && op == OP_ACCU_GLOBAL && bank_ok;
	wire do_clear = run_reg && op == OP_CLEAR_ERR && typ <= 8'(ERR_COUNT);
	wire do_en = run_reg && op == OP_IRQ_ENABLE && (type_global || type_irq_ok);
	wire do_dis = run_reg && op == OP_IRQ_DISABLE && (type_global || type_irq_ok);
	wire do_vec = run_reg && op == OP_VECTOR && type_irq_ok;
	wire do_ret = run_reg && op == OP_IRQ_RETURN;
	wire known = op == OP_ACCU_AXIS || op == OP_ACCU_GLOBAL || op == OP_CLEAR_ERR
		|| op == OP_IRQ_ENABLE || op == OP_IRQ_DISABLE || op == OP_VECTOR || op == OP_IRQ_RETURN;
	wire cmd_ok = do_axis || do_glob || do_clear || do_en || do_dis || do_vec || do_ret;
	wire [7:0] status = bad_sum_reg ? ST_BAD_CSUM : !known ? ST_BAD_CMD
		: op == OP_ACCU_GLOBAL ? ST_BAD_BANK : ST_BAD_TYPE;

	// ----------------------------------------------------------------
	// Execution state
	// ----------------------------------------------------------------
	logic [31:0] accu_reg, xreg_reg, pc_reg, sacc_reg, sx_reg, spc_reg;
	logic [ERR_COUNT-1:0] err_reg, serr_reg;
	logic [NIRQ-1:0] ien_reg;
	logic gen_reg, busy_reg, vec_pend_reg;
	logic [EV_COUNT-1:0] ist_reg, mask_reg;
	logic [IW-1:0] pick;
	logic pick_ok;
	wire [NIRQ-1:0] live = IRQ_REQ & ien_reg & {NIRQ{gen_reg}};
	always_comb begin
		pick = '0;
		pick_ok = 1'b0;
		for (int i = NIRQ - 1; i >= 0; i--) begin
			if (live[i]) begin
				pick = IW'(i);
				pick_ok = 1'b1;
			end
		end
	end
	wire take = pick_ok && !busy_reg && !vec_pend_reg && !run_reg;
	logic [31:0] vec_data;
	aci_vec_mem #(.DEPTH(NIRQ), .AW(IW), .DW(32)) u_vec (
		.clk(CLK_SYS),
		.ce(CE),
		.wr_en(do_vec),
		.wr_addr(typ[IW-1:0]),
		.wr_data(value),
		.rd_addr(pick),
		.rd_data(vec_data)
	);

	// Clear mask per selector; type 0 clears every flag
	logic [ERR_COUNT-1:0] clr_mask;
	for (genvar g = 0; g < ERR_COUNT; g++) begin : g_clr
		assign clr_mask[g] = do_clear && (typ == 8'h00 || typ == 8'(g + 1));
	end
	wire [ERR_COUNT-1:0] err_next = (err_reg & ~clr_mask) | ERR_SET; // Set wins over clear

	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			ien_reg <= '0;
			gen_reg <= 1'b0;
		end else if (CE) begin
			if (do_en && type_global) gen_reg <= 1'b1;
			else if (do_dis && type_global) gen_reg <= 1'b0;
			if (do_en && !type_global) ien_reg[typ[IW-1:0]] <= 1'b1;
			else if (do_dis && !type_global) ien_reg[typ[IW-1:0]] <= 1'b0;
		end
	end

	// Taking an interrupt: save context now, load the vector once the memory has read it
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			err_reg <= '0;
			busy_reg <= 1'b0;
			vec_pend_reg <= 1'b0;
			pc_reg <= RST_WORD;
			sacc_reg <= RST_WORD;
			sx_reg <= RST_WORD;
			spc_reg <= RST_WORD;
			serr_reg <= '0;
		end else if (CE) begin
			err_reg <= err_next;
			vec_pend_reg <= take;
			if (take) begin
				busy_reg <= 1'b1;
				sacc_reg <= accu_reg;
				sx_reg <= xreg_reg;
				spc_reg <= pc_reg;
				serr_reg <= err_reg;
			end
			if (vec_pend_reg) pc_reg <= vec_data;
			else if (do_ret) begin
				pc_reg <= spc_reg;
				err_reg <= serr_reg | ERR_SET;
				busy_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// Reply and parameter write-out
	// ----------------------------------------------------------------
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			REPLY_VALID <= 1'b0;
			REPLY_STATUS <= 8'h00;
			REPLY_INSTR <= 8'h00;
			AXIS_WR <= 1'b0;
			GLOBAL_WR <= 1'b0;
			USERVAR_WR <= 1'b0;
			AXIS_INDEX <= 8'h00;
			AXIS_MOTOR <= 8'h00;
			GLOBAL_INDEX <= 8'h00;
			GLOBAL_BANK <= 8'h00;
			PARAM_DATA <= RST_WORD;
		end else if (CE) begin
			REPLY_VALID <= run_reg || bad_sum_reg;
			if (run_reg || bad_sum_reg) begin
				REPLY_STATUS <= cmd_ok ? ST_OK : status;
				REPLY_INSTR <= op;
			end
			AXIS_WR <= do_axis;
			GLOBAL_WR <= do_glob;
			USERVAR_WR <= do_glob && bank == BANK_USER;
			if (do_axis) begin
				AXIS_INDEX <= typ;
				AXIS_MOTOR <= bank;
				PARAM_DATA <= accu_reg;
			end
			if (do_glob) begin
				GLOBAL_INDEX <= typ;
				GLOBAL_BANK <= bank;
				PARAM_DATA <= accu_reg;
			end
		end
	end
	assign PC_OUT = pc_reg;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic aw_got, w_got;
	logic [7:0] awa_reg;
	logic [31:0] wd_reg;
	logic [3:0] ws_reg;
	assign AWREADY = !aw_got && !BVALID;
	assign WREADY = !w_got && !BVALID;
	wire wr_go = aw_got && w_got && !BVALID;
	wire wr_map = awa_reg == REG_CTRL || awa_reg == REG_MASK || awa_reg == REG_ACCU
		|| awa_reg == REG_XREG;
	wire rd_go = ARVALID && ARREADY;
	assign ARREADY = !RVALID;
	wire rd_status = rd_go && ARADDR == REG_STATUS;
	wire [EV_COUNT-1:0] ev = {take, run_reg && !cmd_ok || bad_sum_reg, run_reg && cmd_ok};
	logic [31:0] rd_mux;
	logic rd_map;
	always_comb begin
		rd_map = 1'b1;
		case (ARADDR)
			REG_CTRL: rd_mux = {31'h0, gen_reg};
			REG_STATUS: rd_mux = {29'h0, ist_reg};
			REG_MASK: rd_mux = {29'h0, mask_reg};
			REG_ACCU: rd_mux = accu_reg;
			REG_XREG: rd_mux = xreg_reg;
			REG_PC: rd_mux = pc_reg;
			REG_IRQ_EN: rd_mux = 32'(ien_reg);
			REG_ERR: rd_mux = {27'h0, err_reg};
			REG_RESULT: rd_mux = {22'h0, busy_reg, vec_pend_reg, REPLY_STATUS};
			default: begin
				rd_mux = RST_WORD;
				rd_map = 1'b0;
			end
		endcase
	end
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) if (be[b]) r[8*b +: 8] = nw[8*b +: 8];
		return r;
	endfunction
	always_ff @(posedge CLK_SYS or negedge RESETN) begin
		if (!RESETN) begin
			aw_got <= 1'b0;
			w_got <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg <= RST_WORD;
			ws_reg <= 4'h0;
			BVALID <= 1'b0;
			BRESP <= RESP_OKAY;
			RVALID <= 1'b0;
			RRESP <= RESP_OKAY;
			RDATA <= RST_WORD;
			ist_reg <= '0;
			mask_reg <= '0;
			accu_reg <= RST_WORD;
			xreg_reg <= RST_WORD;
		end else if (CE) begin
			if (AWVALID && AWREADY) begin
				aw_got <= 1'b1;
				awa_reg <= AWADDR;
			end
			if (WVALID && WREADY) begin
				w_got <= 1'b1;
				wd_reg <= WDATA;
				ws_reg <= WSTRB;
			end
			if (wr_go) begin
				aw_got <= 1'b0;
				w_got <= 1'b0;
				BVALID <= 1'b1;
				BRESP <= wr_map ? RESP_OKAY : RESP_SLVERR;
			end else if (BREADY) BVALID <= 1'b0;
			if (rd_go) begin
				RVALID <= 1'b1;
				RDATA <= rd_mux;
				RRESP <= rd_map ? RESP_OKAY : RESP_SLVERR;
			end else if (RREADY) RVALID <= 1'b0;
			// Events set after a read clears, so none is lost
			ist_reg <= (rd_status ? '0 : ist_reg) | ev;
			if (wr_go && awa_reg == REG_MASK) mask_reg <= wd_reg[EV_COUNT-1:0];
			// Byte strobes apply to the two data registers; the mask takes the low EV_COUNT bits whatever the strobes
			if (wr_go && awa_reg == REG_ACCU) accu_reg <= merge(accu_reg, wd_reg, ws_reg);
			if (wr_go && awa_reg == REG_XREG) xreg_reg <= merge(xreg_reg, wd_reg, ws_reg);
			if (do_ret) begin
				accu_reg <= sacc_reg;
				xreg_reg <= sx_reg;
			end
		end
	end
	assign IRQ = |(ist_reg & mask_reg);

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge CLK_SYS); endclocking
	default disable iff (!RESETN);
	a_axis_write: assert property (CE && do_axis |=> AXIS_WR && PARAM_DATA == $past(accu_reg))
		else $error("axis write missing");
	a_axis_decode: assert property (AXIS_WR |-> $past(op) == OP_ACCU_AXIS)
		else $error("axis write without its opcode");
	a_global_bank: assert property (GLOBAL_WR |-> $past(bank_ok))
		else $error("global write with bad bank");
	a_user_var: assert property (USERVAR_WR |-> GLOBAL_WR && GLOBAL_BANK == BANK_USER)
		else $error("user variable write wrong bank");
	a_clear_all: assert property (CE && do_clear && typ == 8'h00 && ERR_SET == '0
		|=> err_reg == '0)
		else $error("clear all left a flag");
	a_global_en: assert property (CE && do_en && type_global |=> gen_reg)
		else $error("global enable not set");
	a_global_dis: assert property (CE && do_dis && type_global |=> !gen_reg)
		else $error("global enable not cleared");
	a_take_gate: assert property (take |-> gen_reg && ien_reg[pick])
		else $error("interrupt taken while disabled");
	a_vector_jump: assert property (CE && take ##1 CE |=> pc_reg == $past(vec_data))
		else $error("no jump to vector");
	a_return_pc: assert property (CE && do_ret && !vec_pend_reg |=> pc_reg == $past(spc_reg))
		else $error("return did not restore pc");
	a_ok_status: assert property (CE && run_reg && cmd_ok |=> REPLY_VALID && REPLY_STATUS == ST_OK)
		else $error("good frame not acknowledged");
	c_axis: cover property (AXIS_WR);
	c_user: cover property (USERVAR_WR);
	c_take: cover property (take ##[1:20] do_ret);
	c_bad_sum: cover property (bad_sum_reg);
endmodule : aci_exec

// >>> design/aci_pkg.sv
/*
 * Constants shared by the command executor and its vector memory.
 * Assumes one 100 MHz clock domain and an active-low asynchronous reset.
 */
package aci_pkg;
	localparam logic [7:0] OP_IRQ_ENABLE = 8'h19;
	localparam logic [7:0] OP_IRQ_DISABLE = 8'h1a;
	localparam logic [7:0] OP_ACCU_AXIS = 8'h22;
	localparam logic [7:0] OP_ACCU_GLOBAL = 8'h23;
	localparam logic [7:0] OP_CLEAR_ERR = 8'h24;
	localparam logic [7:0] OP_VECTOR = 8'h25;
	localparam logic [7:0] OP_IRQ_RETURN = 8'h26;
	localparam logic [7:0] TYPE_GLOBAL = 8'hff;
	localparam logic [7:0] BANK_USER = 8'h02;
	localparam logic [7:0] BANK_ZERO = 8'h00;
	localparam logic [7:0] BANK_THREE = 8'h03;
	localparam logic [7:0] ST_OK = 8'h64;
	localparam logic [7:0] ST_BAD_CSUM = 8'h01;
	localparam logic [7:0] ST_BAD_CMD = 8'h02;
	localparam logic [7:0] ST_BAD_TYPE = 8'h03;
	localparam logic [7:0] ST_BAD_BANK = 8'h04;
	// Error flag bit positions; clear selector n maps to bit n-1
	localparam int ERR_TIMEOUT = 0;
	localparam int ERR_ALARM = 1;
	localparam int ERR_DEVIATION = 2;
	localparam int ERR_POSITION = 3;
	localparam int ERR_SHUTDOWN = 4;
	localparam int ERR_COUNT = 5;
	// Register byte addresses
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_MASK = 8'h08;
	localparam logic [7:0] REG_ACCU = 8'h0c;
	localparam logic [7:0] REG_XREG = 8'h10;
	localparam logic [7:0] REG_PC = 8'h14;
	localparam logic [7:0] REG_IRQ_EN = 8'h18;
	localparam logic [7:0] REG_ERR = 8'h1c;
	localparam logic [7:0] REG_RESULT = 8'h20;
	localparam logic [1:0] RESP_OKAY = 2'b00;
	localparam logic [1:0] RESP_SLVERR = 2'b10;
	// Interrupt status bits
	localparam int EV_DONE = 0;
	localparam int EV_ERROR = 1;
	localparam int EV_TAKEN = 2;
	localparam int EV_COUNT = 3;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
endpackage : aci_pkg

// >>> design/aci_vec_mem.sv
/*
 * Interrupt vector store: one handler address per interrupt number.
 * Assumes synchronous write and a registered read port.
 */
module aci_vec_mem
	import aci_pkg::*;
#(
	parameter int DEPTH = 16,
	parameter int AW = 4,
	parameter int DW = 32
) (
	// Clock
	input wire logic clk,
	input wire logic ce,
	// Write port
	input wire logic wr_en,
	input wire logic [AW-1:0] wr_addr,
	input wire logic [DW-1:0] wr_data,
	// Read port
	input wire logic [AW-1:0] rd_addr,
	output logic [DW-1:0] rd_data
);
	logic [DW-1:0] mem [DEPTH];

	// A redefinition simply overwrites the entry
	always_ff @(posedge clk) begin
		if (ce && wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		if (ce) begin
			rd_data <= mem[rd_addr];
		end
	end
endmodule : aci_vec_mem

// >>> tb/aci_exec_tb.sv
/*
 * Self-checking bench for the command executor.
 * Assumes the host model feeds frames and the bench acts as AXI4-Lite master.
 */
module aci_exec_tb import aci_pkg::*;;
	timeunit 1ns;
	timeprecision 1ps;
	logic CLK_SYS = 1'b0, RESETN = 1'b0, CE = 1'b1, start = 1'b0, slow = 1'b0, bad = 1'b0, busy;
	logic [3:0] WSTRB = 4'hf;
	logic [63:0] frame = 64'h0;
	logic BYTE_VALID, REPLY_VALID, AXIS_WR, GLOBAL_WR, USERVAR_WR, IRQ;
	logic [7:0] BYTE_DATA, REPLY_STATUS, REPLY_INSTR, AXIS_INDEX, AXIS_MOTOR, GLOBAL_INDEX, GLOBAL_BANK;
	logic [31:0] PARAM_DATA, PC_OUT, RDATA, acc, a1;
	logic [ERR_COUNT-1:0] ERR_SET = '0;
	logic [15:0] IRQ_REQ = '0;
	logic [7:0] AWADDR = 8'h00, ARADDR = 8'h00;
	logic [31:0] WDATA = 32'h0;
	logic AWVALID = 1'b0, WVALID = 1'b0, BREADY = 1'b0, ARVALID = 1'b0, RREADY = 1'b0;
	logic AWREADY, WREADY, BVALID, ARREADY, RVALID;
	logic [1:0] BRESP, RRESP;
	int err_total = 0, n_compared = 0;
	typedef struct {logic [7:0] st, ins; logic [2:0] wr; logic [7:0] idx, sel; logic [31:0] d;} aci_rep_t;
	typedef struct {logic [31:0] d, m; logic [1:0] r;} aci_bus_t;
	aci_rep_t eq[$];
	aci_bus_t bq[$];
	aci_rep_t r;
	aci_bus_t b;
	logic [7:0] bk[4] = '{BANK_ZERO, BANK_USER, BANK_THREE, 8'h01};

	always #5 CLK_SYS = ~CLK_SYS;

	aci_exec #(.NIRQ(16), .IW(4)) aci_exec_i (.CLK_SYS, .RESETN, .CE, .BYTE_VALID, .BYTE_DATA,
		.REPLY_VALID, .REPLY_STATUS, .REPLY_INSTR, .AXIS_WR, .AXIS_INDEX, .AXIS_MOTOR, .GLOBAL_WR,
		.GLOBAL_INDEX, .GLOBAL_BANK, .USERVAR_WR, .PARAM_DATA, .ERR_SET, .IRQ_REQ, .PC_OUT, .AWADDR,
		.AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID, .BREADY, .ARADDR,
		.ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .IRQ);
	aci_host_model aci_host_model_i (.clk(CLK_SYS), .rst_n(RESETN), .start, .slow, .bad_csum(bad),
		.frame, .byte_valid(BYTE_VALID), .byte_data(BYTE_DATA), .busy);

	// ------------------------------------------------------------
	// Reporting
	// ------------------------------------------------------------
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask

	task finish_test;
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask

	task tmo(input int n);
		if (n >= 200) begin
			chk("wait_done", 32'h1, 32'h0);
			finish_test();
		end
	endtask

	// ------------------------------------------------------------
	// Drivers
	// ------------------------------------------------------------
	task send(input logic [7:0] ins, ty, bn, input logic [31:0] v, input logic [7:0] st,
		input logic [2:0] wr);
		int n;
		eq.push_back('{st, ins, wr, ty, bn, acc});
		@(posedge CLK_SYS);
		frame <= {8'($urandom), ins, ty, bn, v};
		start <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
		end while (!busy && n < 200);
		start <= 1'b0;
		while (eq.size() != 0 && n < 200) begin
			@(posedge CLK_SYS);
			n++;
		end
		tmo(n);
	endtask

	task axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] rs);
		int n;
		bq.push_back('{32'h0, 32'h0, rs});
		@(posedge CLK_SYS);
		AWADDR <= a;
		WDATA <= d;
		AWVALID <= 1'b1;
		WVALID <= 1'b1;
		BREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (AWREADY) AWVALID <= 1'b0;
			if (WREADY) WVALID <= 1'b0;
		end while (!(BVALID && BREADY) && n < 200);
		BREADY <= 1'b0;
		tmo(n);
	endtask

	task axr(input logic [7:0] a, input logic [31:0] d, m, input logic [1:0] rs);
		int n;
		bq.push_back('{d, m, rs});
		@(posedge CLK_SYS);
		ARADDR <= a;
		ARVALID <= 1'b1;
		RREADY <= 1'b1;
		n = 0;
		do begin
			@(posedge CLK_SYS);
			n++;
			if (ARREADY) ARVALID <= 1'b0;
		end while (!(RVALID && RREADY) && n < 200);
		RREADY <= 1'b0;
		tmo(n);
	endtask

	// ------------------------------------------------------------
	// Monitor
	// ------------------------------------------------------------
	always @(posedge CLK_SYS) begin
		if (REPLY_VALID === 1'b1) begin
			r = eq.size() ? eq.pop_front() : '{8'hee, 8'hee, 3'b000, 8'h00, 8'h00, 32'h0};
			chk("status", r.st, REPLY_STATUS);
			chk("instr", r.ins, REPLY_INSTR);
			chk("writes", r.wr, {AXIS_WR, GLOBAL_WR | USERVAR_WR, USERVAR_WR});
			if (r.wr[2]) chk("axis_sel", {r.idx, r.sel}, {AXIS_INDEX, AXIS_MOTOR});
			if (r.wr[1]) chk("global_sel", {r.idx, r.sel}, {GLOBAL_INDEX, GLOBAL_BANK});
			if (r.wr[2] | r.wr[1]) chk("param_data", r.d, PARAM_DATA);
		end
		if ((BVALID && BREADY) || (RVALID && RREADY)) begin
			b = bq.pop_front();
			chk("resp", b.r, BVALID ? BRESP : RRESP);
			chk("rdata", b.d, RDATA & b.m);
		end
	end

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	initial begin
		void'($urandom(32'h70a0));
		acc = $urandom();
		repeat (3) @(posedge CLK_SYS);
		RESETN <= 1'b1;
		axr(REG_CTRL, 32'h0, '1, RESP_OKAY);
		axw(REG_ACCU, acc, RESP_OKAY);
		for (int m = 0; m < 3; m++) begin
			slow <= m[0];
			send(OP_ACCU_AXIS, 8'(m + 7), 8'(m), $urandom, ST_OK, 3'b100);
		end
		for (int i = 0; i < 4; i++) begin
			send(OP_ACCU_GLOBAL, 8'd42, bk[i], $urandom, (i == 3) ? ST_BAD_BANK : ST_OK,
				(i == 3) ? 3'b000 : {2'b01, bk[i] == BANK_USER});
		end
		bad <= 1'b1;
		send(OP_ACCU_AXIS, 8'd1, 8'd0, 32'h0, ST_BAD_CSUM, 3'b000);
		bad <= 1'b0;
		ERR_SET <= '1;
		@(posedge CLK_SYS);
		ERR_SET <= '0;
		for (int k = 1; k < 6; k++) begin
			send(OP_CLEAR_ERR, 8'(k), 8'($urandom), $urandom, ST_OK, 3'b000);
			axr(REG_ERR, (32'h1f << k) & 32'h1f, '1, RESP_OKAY);
		end
		ERR_SET <= '1;
		@(posedge CLK_SYS);
		ERR_SET <= '0;
		send(OP_CLEAR_ERR, 8'd0, 8'd0, 32'h0, ST_OK, 3'b000);
		axr(REG_ERR, 32'h0, '1, RESP_OKAY);
		// Flags must not move while the clock enable is low
		CE <= 1'b0;
		ERR_SET <= '1;
		repeat (3) @(posedge CLK_SYS);
		ERR_SET <= '0;
		@(posedge CLK_SYS);
		CE <= 1'b1;
		axr(REG_ERR, 32'h0, '1, RESP_OKAY);
		send(OP_CLEAR_ERR, 8'd6, 8'd0, 32'h0, ST_BAD_TYPE, 3'b000);
		axr(REG_STATUS, 32'h0, 32'h0, RESP_OKAY);
		axw(REG_MASK, 32'h1, RESP_OKAY);
		send(OP_IRQ_ENABLE, 8'd3, 8'd0, 32'h0, ST_OK, 3'b000);
		repeat (2) @(posedge CLK_SYS);
		chk("irq_out", 32'h1, {31'h0, IRQ});
		axr(REG_IRQ_EN, 32'h8, '1, RESP_OKAY);
		axr(REG_STATUS, 32'h1, 32'h1, RESP_OKAY);
		@(posedge CLK_SYS);
		chk("irq_out", 32'h0, {31'h0, IRQ});
		send(OP_IRQ_DISABLE, 8'd3, 8'd0, 32'h0, ST_OK, 3'b000);
		axr(REG_IRQ_EN, 32'h0, '1, RESP_OKAY);
		send(OP_IRQ_ENABLE, 8'd16, 8'd0, 32'h0, ST_BAD_TYPE, 3'b000);
		send(OP_IRQ_ENABLE, TYPE_GLOBAL, 8'd0, 32'h0, ST_OK, 3'b000);
		axr(REG_CTRL, 32'h1, 32'h1, RESP_OKAY);
		send(OP_IRQ_DISABLE, TYPE_GLOBAL, 8'd0, 32'h0, ST_OK, 3'b000);
		axr(REG_CTRL, 32'h0, 32'h1, RESP_OKAY);
		send(OP_VECTOR, 8'd2, 8'd0, 32'h10, ST_OK, 3'b000);
		send(OP_VECTOR, 8'd2, 8'd0, 32'h20, ST_OK, 3'b000);
		a1 = $urandom();
		axw(REG_ACCU, a1, RESP_OKAY);
		axw(REG_XREG, 32'h1234_5678, RESP_OKAY);
		send(OP_IRQ_ENABLE, 8'd2, 8'd0, 32'h0, ST_OK, 3'b000);
		IRQ_REQ[2] <= 1'b1;
		repeat (20) @(posedge CLK_SYS);
		chk("early_pc", 32'h0, PC_OUT);
		send(OP_IRQ_ENABLE, TYPE_GLOBAL, 8'd0, 32'h0, ST_OK, 3'b000);
		for (int n = 0; n < 200 && PC_OUT !== 32'h20; n++) @(posedge CLK_SYS);
		chk("vector_pc", 32'h20, PC_OUT);
		IRQ_REQ <= '0;
		axw(REG_ACCU, ~a1, RESP_OKAY);
		// Only the two low bytes may change under a partial strobe
		WSTRB <= 4'h3;
		axw(REG_XREG, 32'hffff_ffff, RESP_OKAY);
		WSTRB <= 4'hf;
		axr(REG_XREG, 32'h1234_ffff, '1, RESP_OKAY);
		send(OP_IRQ_RETURN, TYPE_GLOBAL, 8'd0, 32'h0, ST_OK, 3'b000);
		chk("return_pc", 32'h0, PC_OUT);
		axr(REG_ACCU, a1, '1, RESP_OKAY);
		axr(REG_XREG, 32'h1234_5678, '1, RESP_OKAY);
		axr(8'h40, 32'h0, '1, RESP_SLVERR);
		axw(REG_PC, 32'h1, RESP_SLVERR);
		finish_test();
	end
endmodule // aci_exec_tb

// >>> tb/aci_host_model.sv
/*
 * Host model: sends one nine-byte command frame per start request.
 * Assumes the bench holds start until busy rises and keeps frame stable meanwhile.
 */
module aci_host_model (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Control from the bench
	input wire logic start,
	input wire logic slow,
	input wire logic bad_csum,
	input wire logic [63:0] frame,
	// Byte stream to the block
	output logic byte_valid,
	output logic [7:0] byte_data,
	output logic busy
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [3:0] idx;
	logic gap;

	// ------------------------------------------------------------
	// Checksum over the first eight bytes
	// ------------------------------------------------------------
	function automatic logic [7:0] csum(input logic [63:0] f);
		logic [7:0] s;
		s = 8'h00;
		for (int i = 0; i < 8; i++) begin
			s = s + f[8*i +: 8];
		end
		return s;
	endfunction

	// ------------------------------------------------------------
	// Byte sender
	// ------------------------------------------------------------
	// Idle data toggles so a stale byte is never mistaken for a live one
	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			byte_valid <= 1'b0;
			byte_data <= 8'h00;
			busy <= 1'b0;
			idx <= 4'h0;
			gap <= 1'b0;
		end else if (!busy || (slow && gap)) begin
			byte_valid <= 1'b0;
			byte_data <= ~byte_data;
			gap <= 1'b0;
			if (!busy && start) begin
				busy <= 1'b1;
				idx <= 4'h0;
			end
		end else begin
			byte_valid <= 1'b1;
			byte_data <= (idx == 4'h8) ? csum(frame) ^ {7'h00, bad_csum} : frame[63-8*idx -: 8];
			gap <= 1'b1;
			idx <= idx + 4'h1;
			if (idx == 4'h8) begin
				busy <= 1'b0;
			end
		end
	end
endmodule // aci_host_model
